//--- tb/nbio_decode_bench.sv
`timescale 1ns/100ps
module nbio_decode_bench;
	// ==========================================================
	// Signals
	logic mclk;
	logic srst;
	logic fetch_valid;
	logic [7:0] fetch_byte;
	logic second_pending;
	logic [3:0] port_index_reg;
	logic [7:0] memory_pointer_pair;
	logic [15:0] user_flags;
	nbio_pkg::nbio_core_wr_t core_wr;
	logic [3:0] mem_rd_data;
	logic [3:0] work_nibble_reg;
	logic [3:0] aux_nibble_reg;
	logic zero_flag;
	nbio_pkg::nbio_pc_t pc_low_load;
	nbio_pkg::nbio_mem_wr_t mem_wr;
	logic [7:0] mem_wr_addr;
	logic [15:0][3:0] port_pin_in;
	logic [15:0][3:0] port_out;
	logic [15:0][3:0] pv;
	logic [3:0] ac, e, idx, pn, im, hb, fsel, res;
	logic [1:0] t;
	logic [7:0] tgt;
	logic ez, tk;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;

	nbio_decode #(.NPORTS(16), .PTR_W(8)) i_nbio_decode (.mclk(mclk), .srst(srst),
		.fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .second_pending(second_pending),
		.port_index_reg(port_index_reg), .memory_pointer_pair(memory_pointer_pair),
		.user_flags(user_flags), .core_wr(core_wr), .mem_rd_data(mem_rd_data),
		.work_nibble_reg(work_nibble_reg), .aux_nibble_reg(aux_nibble_reg),
		.zero_flag(zero_flag), .pc_low_load(pc_low_load), .mem_wr(mem_wr),
		.mem_wr_addr(mem_wr_addr), .port_pin_in(port_pin_in), .port_out(port_out));

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ==========================================================
	// Helpers
	function automatic logic [3:0] bit_op(logic [3:0] v, logic [1:0] b, logic set);
		logic [3:0] m;
		m = 4'h1 << b;
		return set ? (v | m) : (v & ~m);
	endfunction : bit_op

	function automatic logic taken(logic [3:0] hi, logic cond);
		return (hi == 4'hD || hi == 4'hF) ? cond : ~cond;
	endfunction : taken

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic run(input logic [7:0] b0, input logic [7:0] b1, input bit two);
		fetch_valid = 1'b1;
		fetch_byte = b0;
		@(negedge mclk);
		if (two)
		begin
			fetch_byte = b1;
			@(negedge mclk);
		end
		fetch_valid = 1'b0;
	endtask : run

	task automatic set_core(input logic [3:0] a, input logic [3:0] x, input logic z);
		core_wr = {1'b1, a, 1'b1, x, 1'b1, z};
		@(negedge mclk);
		core_wr = '0;
	endtask : set_core

	task end_sim;
		$display("Checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			end_sim;
		end
	end

	// ==========================================================
	// Sequence
	initial
	begin
		srst = 1'b1;
		fetch_valid = 1'b0;
		fetch_byte = 8'h00;
		port_index_reg = 4'h0;
		memory_pointer_pair = 8'h00;
		user_flags = 16'h0000;
		core_wr = '0;
		mem_rd_data = 4'h0;
		port_pin_in = '0;
		void'($urandom(32'h8B904791));
		repeat (8) @(negedge mclk);
		srst = 1'b0;
		chk({work_nibble_reg, aux_nibble_reg}, 8'h00);
		chk({5'h00, zero_flag, pc_low_load.load, mem_wr.we}, 8'h00);
		for (int it = 0; it < 24; it++)
		begin
			// Corner pin patterns first, then random ones
			for (int k = 0; k < 16; k++)
				port_pin_in[k] = (it == 0) ? 4'h0 : (it == 1) ? 4'hF : 4'($urandom);
			user_flags = 16'($urandom);
			port_index_reg = 4'($urandom);
			memory_pointer_pair = 8'($urandom);
			mem_rd_data = 4'($urandom);
			ac = 4'($urandom);
			e = 4'($urandom);
			ez = 1'($urandom);
			t = 2'($urandom);
			pn = 4'($urandom);
			tgt = 8'($urandom);
			fsel = 4'($urandom);
			do
				im = 4'($urandom);
			while (im == 4'h6 || im == 4'h7 || im == 4'hD);
			for (int op = 0; op < 17; op++)
			begin
				set_core(ac, e, ez);
				repeat (2) @(negedge mclk);
				idx = port_index_reg;
				pv = port_pin_in;
				tk = 1'b0;
				hb = (op == 0) ? 4'hD : (op == 1) ? 4'h9 : (op == 2) ? 4'hF : 4'hB;
				case (op)
					0, 1:
					begin
						run({hb, tgt[7:4]}, {4'hD, tgt[3:0]}, 1'b1);
						tk = taken(hb, ez);
					end
					2, 3:
					begin
						run({hb, tgt[7:4]}, {fsel, tgt[3:0]}, 1'b1);
						tk = taken(hb, user_flags[fsel]);
					end
					4:
					begin
						run(8'h20, 8'h00, 1'b0);
						ac = pv[0];
						ez = (ac == 4'h0);
					end
					5:
					begin
						run(8'h26, 8'h00, 1'b0);
						ac = pv[idx];
						ez = (ac == 4'h0);
					end
					6:
					begin
						run(8'h19, 8'h00, 1'b0);
						chk({3'h0, mem_wr.we, mem_wr.data}, {4'h1, pv[idx]});
						chk(mem_wr_addr, memory_pointer_pair);
					end
					7:
					begin
						run(8'hC6, {4'hF, pn}, 1'b1);
						ac = pv[pn];
						ez = (ac == 4'h0);
					end
					8:
					begin
						run(8'hCD, 8'hF4, 1'b1);
						e = pv[4];
						ac = pv[5];
					end
					9:
					begin
						run(8'h25, 8'h00, 1'b0);
						chk({4'h0, port_out[idx]}, {4'h0, ac});
					end
					10:
					begin
						run(8'h1A, 8'h00, 1'b0);
						chk({4'h0, port_out[idx]}, {4'h0, mem_rd_data});
					end
					11:
					begin
						run(8'hC7, {tgt[7:4], pn}, 1'b1);
						chk({4'h0, port_out[pn]}, {4'h0, ac});
					end
					12:
					begin
						run(8'hCD, 8'hF5, 1'b1);
						chk({port_out[4], port_out[5]}, {e, ac});
					end
					13:
					begin
						run({6'h02, t}, 8'h00, 1'b0);
						chk({4'h0, port_out[idx]}, {4'h0, bit_op(pv[idx], t, 1'b1)});
					end
					14:
					begin
						run({6'h0A, t}, 8'h00, 1'b0);
						res = bit_op(pv[idx], t, 1'b0);
						chk({4'h0, port_out[idx]}, {4'h0, res});
						ez = (res == 4'h0);
					end
					default:
					begin
						run({4'hC, im}, {(op == 15) ? 4'h5 : 4'h4, pn}, 1'b1);
						res = (op == 15) ? (pv[pn] & im) : (pv[pn] | im);
						chk({4'h0, port_out[pn]}, {4'h0, res});
						ez = (res == 4'h0);
					end
				endcase
				chk({7'h00, pc_low_load.load}, {7'h00, tk});
				if (tk)
					chk(pc_low_load.low, tgt);
				chk({work_nibble_reg, aux_nibble_reg}, {ac, e});
				chk({6'h00, second_pending, zero_flag}, {7'h00, ez});
			end
		end
		end_sim;
	end
endmodule : nbio_decode_bench

//--- verilog/nbio_decode.sv
`timescale 1ns/100ps
`include "nbio_regs.svh"

module nbio_decode #(
	parameter int NPORTS = 16,
	parameter int PTR_W = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Instruction fetch
	input wire logic fetch_valid,
	input wire logic [7:0] fetch_byte,
	output logic second_pending,
	// Core state
	input wire logic [3:0] port_index_reg,
	input wire logic [PTR_W-1:0] memory_pointer_pair,
	input wire logic [15:0] user_flags,
	input wire nbio_pkg::nbio_core_wr_t core_wr,
	input wire logic [3:0] mem_rd_data,
	output logic [3:0] work_nibble_reg,
	output logic [3:0] aux_nibble_reg,
	output logic zero_flag,
	// Program counter and memory
	output nbio_pkg::nbio_pc_t pc_low_load,
	output nbio_pkg::nbio_mem_wr_t mem_wr,
	output logic [PTR_W-1:0] mem_wr_addr,
	// Ports
	input wire logic [NPORTS-1:0][3:0] port_pin_in,
	output logic [NPORTS-1:0][3:0] port_out
);

	// ==========================================================
	// Elaboration checks
	generate
		if (NPORTS != 16)
		begin : g_bad_ports
			$error("nbio_decode: a 4-bit port field needs exactly 16 ports");
		end
		if (PTR_W < 1)
		begin : g_bad_hl
			$error("nbio_decode: memory pointer width must be positive");
		end
	endgenerate

	// ==========================================================
	// Helpers
	function automatic logic nib_zero(input logic [3:0] v);
		nib_zero = (v == 4'h0);
	endfunction : nib_zero

	function automatic logic [3:0] bit_mask(input logic [1:0] t);
		bit_mask = 4'h1 << t;
	endfunction : bit_mask

	// ==========================================================
	// Pin synchronisers
	logic [NPORTS-1:0][3:0] pin_s1_ff;
	logic [NPORTS-1:0][3:0] pin_s2_ff;

	always_ff @(posedge mclk)
	begin
		pin_s1_ff <= port_pin_in;
		pin_s2_ff <= pin_s1_ff;
	end

	// ==========================================================
	// State
	nbio_pkg::nbio_state_t state_ff;
	nbio_pkg::nbio_state_t nxt_state;
	logic [7:0] first_ff;
	logic [3:0] ac_ff;
	logic [3:0] e_ff;
	logic zflag_ff;
	logic pc_load_ff;
	logic [7:0] pc_low_ff;
	logic mem_we_ff;
	logic [3:0] mem_data_ff;
	logic [PTR_W-1:0] mem_addr_ff;
	logic [NPORTS-1:0][3:0] port_ff;

	// Decoded action of the current byte
	logic ex_ac_we;
	logic [3:0] ex_ac;
	logic ex_e_we;
	logic ex_zflag_we;
	logic [3:0] ex_zflag_val;
	logic ex_pc_ld;
	logic ex_mem_we;
	logic ex_p_we;
	logic [3:0] ex_p_idx;
	logic [3:0] ex_p_val;
	logic ex_p2_we;
	logic [3:0] cur_port;

	assign cur_port = pin_s2_ff[port_index_reg];
	assign second_pending = (state_ff == nbio_pkg::NBIO_ST_SECOND);

	// ==========================================================
	// Decode
	always_comb
	begin
		nxt_state = nbio_pkg::NBIO_ST_FIRST;
		ex_ac_we = 1'b0;
		ex_ac = 4'h0;
		ex_e_we = 1'b0;
		ex_zflag_we = 1'b0;
		ex_zflag_val = 4'h0;
		ex_pc_ld = 1'b0;
		ex_mem_we = 1'b0;
		ex_p_we = 1'b0;
		ex_p_idx = port_index_reg;
		ex_p_val = 4'h0;
		ex_p2_we = 1'b0;
		if (!fetch_valid)
			nxt_state = state_ff;
		else if (state_ff == nbio_pkg::NBIO_ST_FIRST)
		begin
			unique case (fetch_byte[7:4])
				`NBIO_HI_ZERO_SET, `NBIO_HI_ZERO_CLR, `NBIO_HI_FLAG_SET,
				`NBIO_HI_FLAG_CLR, `NBIO_HI_PREFIX:
					nxt_state = nbio_pkg::NBIO_ST_SECOND;
				default:
					nxt_state = nbio_pkg::NBIO_ST_FIRST;
			endcase
			if (fetch_byte == `NBIO_OP_READ_FIRST_PORT)
			begin
				ex_ac_we = 1'b1;
				ex_ac = pin_s2_ff[`NBIO_PORT_FIRST];
				ex_zflag_we = 1'b1;
				ex_zflag_val = ex_ac;
			end
			if (fetch_byte == `NBIO_OP_PORT_TO_ACC)
			begin
				ex_ac_we = 1'b1;
				ex_ac = cur_port;
				ex_zflag_we = 1'b1;
				ex_zflag_val = cur_port;
			end
			if (fetch_byte == `NBIO_OP_PORT_TO_MEM)
				ex_mem_we = 1'b1;
			if (fetch_byte == `NBIO_OP_ACC_TO_PORT)
			begin
				ex_p_we = 1'b1;
				ex_p_val = ac_ff;
			end
			if (fetch_byte == `NBIO_OP_MEM_TO_PORT)
			begin
				ex_p_we = 1'b1;
				ex_p_val = mem_rd_data;
			end
			if (fetch_byte[7:2] == `NBIO_OP_BIT_SET_HI)
			begin
				ex_p_we = 1'b1;
				ex_p_val = cur_port | bit_mask(fetch_byte[1:0]);
			end
			if (fetch_byte[7:2] == `NBIO_OP_BIT_CLR_HI)
			begin
				ex_p_we = 1'b1;
				ex_p_val = cur_port & ~bit_mask(fetch_byte[1:0]);
				ex_zflag_we = 1'b1;
				ex_zflag_val = ex_p_val;
			end
		end
		else
		begin
			unique case (first_ff[7:4])
				`NBIO_HI_ZERO_SET, `NBIO_HI_ZERO_CLR:
					ex_pc_ld = (fetch_byte[7:4] == `NBIO_SB_ZERO_BR) &&
						(zflag_ff == (first_ff[7:4] == `NBIO_HI_ZERO_SET));
				`NBIO_HI_FLAG_SET, `NBIO_HI_FLAG_CLR:
					ex_pc_ld = (user_flags[fetch_byte[7:4]] ==
						(first_ff[7:4] == `NBIO_HI_FLAG_SET));
				`NBIO_HI_PREFIX:
				begin
					if (first_ff == `NBIO_OP_DIRECT_READ)
					begin
						if (fetch_byte[7:4] == `NBIO_SB_DIRECT_READ)
						begin
							ex_ac_we = 1'b1;
							ex_ac = pin_s2_ff[fetch_byte[3:0]];
							ex_zflag_we = 1'b1;
							ex_zflag_val = ex_ac;
						end
					end
					else if (first_ff == `NBIO_OP_DIRECT_WRITE)
					begin
						ex_p_we = 1'b1;
						ex_p_idx = fetch_byte[3:0];
						ex_p_val = ac_ff;
					end
					else if (first_ff == `NBIO_OP_PAIRED)
					begin
						if (fetch_byte == `NBIO_SB_PAIRED_READ)
						begin
							ex_e_we = 1'b1;
							ex_ac_we = 1'b1;
							ex_ac = pin_s2_ff[`NBIO_PORT_WORK];
						end
						ex_p2_we = (fetch_byte == `NBIO_SB_PAIRED_WRITE);
					end
					else if (fetch_byte[7:4] == `NBIO_SB_MASK_AND)
					begin
						ex_p_we = 1'b1;
						ex_p_idx = fetch_byte[3:0];
						ex_p_val = pin_s2_ff[fetch_byte[3:0]] & first_ff[3:0];
						ex_zflag_we = 1'b1;
						ex_zflag_val = ex_p_val;
					end
					else if (fetch_byte[7:4] == `NBIO_SB_MASK_OR)
					begin
						ex_p_we = 1'b1;
						ex_p_idx = fetch_byte[3:0];
						ex_p_val = pin_s2_ff[fetch_byte[3:0]] | first_ff[3:0];
						ex_zflag_we = 1'b1;
						ex_zflag_val = ex_p_val;
					end
				end
				default:
					ex_pc_ld = 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_ff <= nbio_pkg::NBIO_ST_FIRST;
			first_ff <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			if (fetch_valid && state_ff == nbio_pkg::NBIO_ST_FIRST)
				first_ff <= fetch_byte;
		end
	end

	// ==========================================================
	// Working, auxiliary and zero flag registers
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ac_ff <= `NBIO_RST_NIBBLE;
			e_ff <= `NBIO_RST_NIBBLE;
			zflag_ff <= 1'b0;
		end
		else
		begin
			if (ex_ac_we)
				ac_ff <= ex_ac;
			else if (core_wr.ac_we)
				ac_ff <= core_wr.ac;
			if (ex_e_we)
				e_ff <= pin_s2_ff[`NBIO_PORT_AUX];
			else if (core_wr.e_we)
				e_ff <= core_wr.e;
			if (ex_zflag_we)
				zflag_ff <= nib_zero(ex_zflag_val);
			else if (core_wr.zflag_we)
				zflag_ff <= core_wr.zflag;
		end
	end

	// ==========================================================
	// Program counter and memory requests
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pc_load_ff <= 1'b0;
			pc_low_ff <= `NBIO_RST_PC_LOW;
			mem_we_ff <= 1'b0;
			mem_data_ff <= `NBIO_RST_NIBBLE;
			mem_addr_ff <= '0;
		end
		else
		begin
			pc_load_ff <= ex_pc_ld;
			if (ex_pc_ld)
				pc_low_ff <= {first_ff[3:0], fetch_byte[3:0]};
			mem_we_ff <= ex_mem_we;
			if (ex_mem_we)
			begin
				mem_data_ff <= cur_port;
				mem_addr_ff <= memory_pointer_pair;
			end
		end
	end

	// ==========================================================
	// Port output latches
	always_ff @(posedge mclk)
	begin
		if (srst)
			port_ff <= '0;
		else if (ex_p2_we)
		begin
			port_ff[`NBIO_PORT_AUX] <= e_ff;
			port_ff[`NBIO_PORT_WORK] <= ac_ff;
		end
		else if (ex_p_we)
			port_ff[ex_p_idx] <= ex_p_val;
	end

	assign work_nibble_reg = ac_ff;
	assign aux_nibble_reg = e_ff;
	assign zero_flag = zflag_ff;
	assign pc_low_load = '{load: pc_load_ff, low: pc_low_ff};
	assign mem_wr = '{we: mem_we_ff, data: mem_data_ff};
	assign mem_wr_addr = mem_addr_ff;
	assign port_out = port_ff;

	// ==========================================================
	// Checks
	sequence s_first(logic [7:0] op);
		fetch_valid && state_ff == nbio_pkg::NBIO_ST_FIRST && fetch_byte == op;
	endsequence

	sequence s_zero_pair;
		fetch_valid && state_ff == nbio_pkg::NBIO_ST_FIRST
			&& fetch_byte[7:4] == `NBIO_HI_ZERO_SET
			##1 fetch_valid[*1] ##0 fetch_byte[7:4] == `NBIO_SB_ZERO_BR;
	endsequence

	zero_branch_a: assert property (@(posedge mclk) disable iff (srst)
		s_zero_pair ##0 zflag_ff |=> pc_low_load.load
			&& pc_low_load.low[3:0] == $past(fetch_byte[3:0]))
		else $error("zero branch did not load target");

	flag_branch_a: assert property (@(posedge mclk) disable iff (srst)
		(second_pending && fetch_valid && first_ff[7:4] == `NBIO_HI_FLAG_CLR
			&& user_flags[fetch_byte[7:4]]) |=> !pc_low_load.load)
		else $error("negated flag branch taken with flag set");

	first_port_a: assert property (@(posedge mclk) disable iff (srst)
		s_first(`NBIO_OP_READ_FIRST_PORT) |=> work_nibble_reg == $past(pin_s2_ff[0])
			&& zero_flag == (work_nibble_reg == 4'h0))
		else $error("port 0 read wrong");

	port_mem_a: assert property (@(posedge mclk) disable iff (srst)
		s_first(`NBIO_OP_PORT_TO_MEM) ##0 !core_wr.zflag_we |=> mem_wr.we
			&& mem_wr.data == $past(cur_port)
			&& mem_wr_addr == $past(memory_pointer_pair) && $stable(zero_flag))
		else $error("port to memory wrong");

	acc_port_a: assert property (@(posedge mclk) disable iff (srst)
		s_first(`NBIO_OP_ACC_TO_PORT) |=> port_out[$past(port_index_reg)]
			== $past(work_nibble_reg))
		else $error("work nibble not written to port");

	bit_clear_a: assert property (@(posedge mclk) disable iff (srst)
		(fetch_valid && !second_pending && fetch_byte[7:2] == `NBIO_OP_BIT_CLR_HI)
			|=> !port_out[$past(port_index_reg)][$past(fetch_byte[1:0])])
		else $error("port bit not cleared");

	paired_write_a: assert property (@(posedge mclk) disable iff (srst)
		(second_pending && fetch_valid && first_ff == `NBIO_OP_PAIRED
			&& fetch_byte == `NBIO_SB_PAIRED_WRITE)
			|=> port_out[4] == $past(aux_nibble_reg) && port_out[5] == $past(work_nibble_reg))
		else $error("paired write wrong");

	mask_and_a: assert property (@(posedge mclk) disable iff (srst)
		(second_pending && fetch_valid && first_ff[7:4] == `NBIO_HI_PREFIX
			&& first_ff != `NBIO_OP_DIRECT_READ && first_ff != `NBIO_OP_DIRECT_WRITE
			&& first_ff != `NBIO_OP_PAIRED && fetch_byte[7:4] == `NBIO_SB_MASK_AND)
			|=> (port_out[$past(fetch_byte[3:0])] & ~$past(first_ff[3:0])) == 4'h0)
		else $error("masked AND left a bit set");

	two_byte_a: assert property (@(posedge mclk) disable iff (srst)
		s_first(`NBIO_OP_DIRECT_READ) |=> second_pending)
		else $error("direct read did not wait for its second byte");

endmodule : nbio_decode

//--- verilog/nbio_pkg.sv
package nbio_pkg;

	// ==========================================================
	// Decoder sequencing
	typedef enum logic {
		NBIO_ST_FIRST,
		NBIO_ST_SECOND
	} nbio_state_t;

	// ==========================================================
	// Writes from the rest of the core into the shared registers
	typedef struct packed {
		logic ac_we;
		logic [3:0] ac;
		logic e_we;
		logic [3:0] e;
		logic zflag_we;
		logic zflag;
	} nbio_core_wr_t;

	// Low program counter replacement
	typedef struct packed {
		logic load;
		logic [7:0] low;
	} nbio_pc_t;

	// Memory nibble write at the pointer pair
	typedef struct packed {
		logic we;
		logic [3:0] data;
	} nbio_mem_wr_t;

endpackage : nbio_pkg

//--- verilog/nbio_regs.svh
`ifndef NBIO_REGS_SVH
`define NBIO_REGS_SVH

// ==========================================================
// One-byte opcodes
`define NBIO_OP_READ_FIRST_PORT 8'h20
`define NBIO_OP_PORT_TO_ACC 8'h26
`define NBIO_OP_PORT_TO_MEM 8'h19
`define NBIO_OP_ACC_TO_PORT 8'h25
`define NBIO_OP_MEM_TO_PORT 8'h1A
`define NBIO_OP_BIT_SET_HI 6'h02
`define NBIO_OP_BIT_CLR_HI 6'h0A

// ==========================================================
// Two-byte opcodes: first byte
`define NBIO_HI_ZERO_SET 4'hD
`define NBIO_HI_ZERO_CLR 4'h9
`define NBIO_HI_FLAG_SET 4'hF
`define NBIO_HI_FLAG_CLR 4'hB
`define NBIO_HI_PREFIX 4'hC
`define NBIO_OP_DIRECT_READ 8'hC6
`define NBIO_OP_DIRECT_WRITE 8'hC7
`define NBIO_OP_PAIRED 8'hCD

// ==========================================================
// Two-byte opcodes: second byte
`define NBIO_SB_ZERO_BR 4'hD
`define NBIO_SB_DIRECT_READ 4'hF
`define NBIO_SB_PAIRED_READ 8'hF4
`define NBIO_SB_PAIRED_WRITE 8'hF5
`define NBIO_SB_MASK_AND 4'h5
`define NBIO_SB_MASK_OR 4'h4

// ==========================================================
// Fixed port numbers and reset values
`define NBIO_PORT_FIRST 4'h0
`define NBIO_PORT_AUX 4'h4
`define NBIO_PORT_WORK 4'h5
`define NBIO_RST_NIBBLE 4'h0
`define NBIO_RST_PC_LOW 8'h00

`endif
